/* File: rtl/std_timer.sv */
// Purpose: 10-bit standard timer with comparators a and p, compare, timer and pwm modes
// Assumes: wishbone classic slave; timer clock ticks from tick_i[clk_sel] (sync to core_clk_i)
// Notes:   single pulse and capture modes are not built; capture mode counts, clears and flags on match p only
//
// Behaviour
// - clear-select 1 clears on match a; 0 clears on match p or overflow.
// - overflow clears only when compare p value is zero, else match p clears.
// - clear-select ignored in pwm, single pulse and capture modes.
// - counter readable as low byte and two-bit high byte, upper bits zero.
// - compare a value held in two writable bytes, both reset to zero.
// - mode code 00 selects compare match output mode.
// - compare mode, clear-select 0: match a and match p raise their flags.
// - clear-select 1 raises only match a flag, never match p flag.
// - compare a zero: counter overflows after 3ff, no match a flag.
// - compare mode changes pin only on match a.
// - match a sets pin high, low or toggles per pin action; zero keeps.
// - enable rising in compare mode loads pin with initial level.
// - mode 11 counts and flags like compare mode, pin unused.
// - pwm needs mode 10 and pin action 10 set by software.
// - in pwm, swap picks period and duty comparator; clear-select unused.
// - swap 0: period is p times 128 or 1024; duty is compare a.
// - swap 1: period from compare a; duty p times 128 or 1024.
// - duty at or above period gives 100 percent duty.
// - pwm raises match a and match p flags on their matches.
// - pwm: initial level sets polarity, pin action enables or forces, invert flips.
// - pwm counting continues while pin is forced.
// - compare pin action codes: none, low, high, toggle.
// - pwm pin action codes: force inactive, force active, waveform.
// - enable rising resets counter to zero; falling keeps value.
// - compare p value checked against counter bits 9 to 7.
module std_timer
	import std_timer_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        reset_i,
	input  wire logic [7:0]  tick_i,       // timer clock enables, one per clock select code
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	output logic             timer_pin_o,
	output logic             timer_pin_oe_n_o,
	output logic             match_a_flag_o,
	output logic             match_p_flag_o
);
	ctrl0_t      ctrl0_ff, nxt_ctrl0;
	ctrl1_t      ctrl1_ff, nxt_ctrl1;
	logic [9:0]  cmpa_ff, nxt_cmpa;
	logic [9:0]  cnt_ff, nxt_cnt;
	logic        en_d_ff, nxt_en_d;
	logic        pin_ff, nxt_pin;
	logic        pwm_ff, nxt_pwm;
	logic        fa_ff, nxt_fa;
	logic        fp_ff, nxt_fp;
	logic        ack_ff, nxt_ack;
	logic [31:0] rdat_ff, nxt_rdat;
	logic        oe_n_ff, nxt_oe_n;
	wb_req_t     req;

	// combined bus view
	assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};

	// decoded mode and compare terms
	logic       tick, run, en_rise, is_pwm, cmp_like, act_lvl;
	logic       match_a, match_p;
	logic [9:0] per_v, duty_v;
	logic       wr_strobe, rd_strobe;
	always_comb begin
		tick     = tick_i[ctrl0_ff.clk_sel];
		en_rise  = ctrl0_ff.timer_enable & ~en_d_ff;
		run      = ctrl0_ff.timer_enable & ~ctrl0_ff.pause & tick;
		is_pwm   = ctrl1_ff.operating_mode_select == MODE_PWM;
		act_lvl  = ctrl1_ff.output_initial_level ^ ctrl1_ff.output_invert;
		cmp_like = (ctrl1_ff.operating_mode_select == MODE_CMP) ||
			(ctrl1_ff.operating_mode_select == MODE_TMR);
		// comparator a needs a nonzero value; a zero value lets the counter wrap
		match_a  = run && (cmpa_ff != 10'h000) && (cnt_ff == cmpa_ff);
		match_p  = run && (ctrl0_ff.compare_p_value != 3'h0) &&
			(cnt_ff[9:P_SHIFT] == ctrl0_ff.compare_p_value);
		per_v    = (ctrl0_ff.compare_p_value == 3'h0) ? CNT_MAX :
			{ctrl0_ff.compare_p_value, 7'h00};
		duty_v   = cmpa_ff;
		if (ctrl1_ff.period_duty_swap) begin
			per_v  = cmpa_ff;
			duty_v = (ctrl0_ff.compare_p_value == 3'h0) ? CNT_MAX : {ctrl0_ff.compare_p_value, 7'h00};
		end
		wr_strobe = req.cyc & req.stb & req.we & ~ack_ff & req.sel[0];
		rd_strobe = req.cyc & req.stb & ~ack_ff;
	end

	// counter, flags and pin next state
	always_comb begin
		nxt_cnt  = cnt_ff;
		nxt_en_d = ctrl0_ff.timer_enable;
		nxt_pin  = pin_ff;
		nxt_pwm  = pwm_ff;
		nxt_fa   = fa_ff;
		nxt_fp   = fp_ff;
		nxt_oe_n = ~(ctrl0_ff.timer_enable | en_d_ff) | (ctrl1_ff.operating_mode_select[0]);
		// software clear first so a same-cycle event wins
		if (wr_strobe && req.adr == OFS_STATUS) begin
			if (req.dat[0])
				nxt_fa = 1'b0;
			if (req.dat[1])
				nxt_fp = 1'b0;
		end
		if (en_rise) begin
			nxt_cnt = 10'h000;
			nxt_pin = ctrl1_ff.output_initial_level;
			nxt_pwm = 1'b1; // a restarted period opens with the active phase
		end else if (run) begin
			if (is_pwm) begin
				// period comparator clears the counter, duty comparator ends the active phase
				nxt_fa = nxt_fa | match_a;
				nxt_fp = nxt_fp | match_p;
				if (ctrl1_ff.period_duty_swap ? (cnt_ff == per_v) : (match_p || cnt_ff == CNT_MAX)) begin
					nxt_cnt = 10'h000;
					nxt_pwm = 1'b1;
				end else begin
					nxt_cnt = cnt_ff + 10'h001;
					if ((cnt_ff + 10'h001 >= duty_v) && (duty_v < per_v))
						nxt_pwm = 1'b0;
				end
			end else if (cmp_like && ctrl1_ff.counter_clear_select) begin
				nxt_fa  = nxt_fa | match_a;
				nxt_cnt = match_a ? 10'h000 : cnt_ff + 10'h001;
			end else begin
				// capture mode lands here too with clear-select ignored
				if (cmp_like)
					nxt_fa = nxt_fa | match_a;
				nxt_fp  = nxt_fp | match_p;
				nxt_cnt = match_p ? 10'h000 : cnt_ff + 10'h001;
			end
			if (cmp_like && match_a && ctrl1_ff.operating_mode_select == MODE_CMP) begin
				unique case (ctrl1_ff.pin_action_select)
					PIN_NONE: nxt_pin = pin_ff;
					PIN_LOW:  nxt_pin = 1'b0;
					PIN_HIGH: nxt_pin = 1'b1;
					PIN_TOG:  nxt_pin = ~pin_ff;
				endcase
			end
		end
		if (is_pwm) begin
			// pin follows forced or waveform level; counting is unaffected
			unique case (ctrl1_ff.pin_action_select)
				// the invert bit flips every pwm level, forced ones included
				PIN_NONE: nxt_pin = ~act_lvl;
				PIN_LOW:  nxt_pin = act_lvl;
				PIN_HIGH: nxt_pin = nxt_pwm ? act_lvl : ~act_lvl;
				PIN_TOG:  nxt_pin = pin_ff;
			endcase
		end
	end

	// register file next state
	always_comb begin
		nxt_ctrl0 = ctrl0_ff;
		nxt_ctrl1 = ctrl1_ff;
		nxt_cmpa  = cmpa_ff;
		nxt_ack   = rd_strobe;
		nxt_rdat  = 32'h0000_0000;
		if (wr_strobe) begin
			unique case (req.adr)
				OFS_CTRL0:   nxt_ctrl0 = ctrl0_t'(req.dat[7:0]);
				OFS_CTRL1:   nxt_ctrl1 = ctrl1_t'(req.dat[7:0]);
				OFS_CMPA_LO: nxt_cmpa[7:0] = req.dat[7:0];
				OFS_CMPA_HI: nxt_cmpa[9:8] = req.dat[1:0];
				default:     nxt_cmpa = cmpa_ff;
			endcase
		end
		if (rd_strobe && !req.we) begin
			unique case (req.adr)
				OFS_CTRL0:   nxt_rdat = {24'h000000, ctrl0_ff};
				OFS_CTRL1:   nxt_rdat = {24'h000000, ctrl1_ff};
				OFS_CNT_LO:  nxt_rdat = {24'h000000, cnt_ff[7:0]};
				OFS_CNT_HI:  nxt_rdat = {30'h00000000, cnt_ff[9:8]};
				OFS_CMPA_LO: nxt_rdat = {24'h000000, cmpa_ff[7:0]};
				OFS_CMPA_HI: nxt_rdat = {30'h00000000, cmpa_ff[9:8]};
				OFS_STATUS:  nxt_rdat = {30'h00000000, fp_ff, fa_ff};
				default:     nxt_rdat = 32'h0000_0000; // unmapped reads zero, still acked
			endcase
		end
	end

	// all state registered here
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			ctrl0_ff <= ctrl0_t'(RST_BYTE);
			ctrl1_ff <= ctrl1_t'(RST_BYTE);
			cmpa_ff  <= 10'h000;
			cnt_ff   <= 10'h000;
			en_d_ff  <= 1'b0;
			pin_ff   <= 1'b0;
			pwm_ff   <= 1'b0;
			fa_ff    <= 1'b0;
			fp_ff    <= 1'b0;
			ack_ff   <= 1'b0;
			rdat_ff  <= 32'h0000_0000;
			oe_n_ff  <= 1'b1;
		end else begin
			ctrl0_ff <= nxt_ctrl0;
			ctrl1_ff <= nxt_ctrl1;
			cmpa_ff  <= nxt_cmpa;
			cnt_ff   <= nxt_cnt;
			en_d_ff  <= nxt_en_d;
			pin_ff   <= nxt_pin;
			pwm_ff   <= nxt_pwm;
			fa_ff    <= nxt_fa;
			fp_ff    <= nxt_fp;
			ack_ff   <= nxt_ack;
			rdat_ff  <= nxt_rdat;
			oe_n_ff  <= nxt_oe_n;
		end
	end

	assign wb_dat_o         = rdat_ff;
	assign wb_ack_o         = ack_ff;
	assign timer_pin_o      = pin_ff;
	assign timer_pin_oe_n_o = oe_n_ff;
	assign match_a_flag_o   = fa_ff;
	assign match_p_flag_o   = fp_ff;

	// enable rise zeroes the counter on the next edge
	a_enable_rise_clr: assert property (@(posedge core_clk_i) disable iff (reset_i)
		en_rise |=> cnt_ff == 10'h000)
		else $error("counter not cleared on enable rise");
	a_clr_sel_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		cmp_like && ctrl1_ff.counter_clear_select && !en_rise && match_a |=> cnt_ff == 10'h000)
		else $error("match a did not clear counter");
	a_no_p_flag: assert property (@(posedge core_clk_i) disable iff (reset_i)
		cmp_like && ctrl1_ff.counter_clear_select && !fp_ff |=> !fp_ff)
		else $error("match p flag raised with clear select a");
	a_zero_a_wrap: assert property (@(posedge core_clk_i) disable iff (reset_i)
		cmp_like && run && !en_rise && cmpa_ff == 10'h000 && !fa_ff |=> !fa_ff)
		else $error("match a flag with zero compare a");
	a_init_level: assert property (@(posedge core_clk_i) disable iff (reset_i)
		en_rise && !is_pwm |=> pin_ff == $past(ctrl1_ff.output_initial_level))
		else $error("pin not loaded with initial level");
	a_toggle_pin: assert property (@(posedge core_clk_i) disable iff (reset_i)
		ctrl1_ff.operating_mode_select == MODE_CMP && match_a && !en_rise &&
		ctrl1_ff.pin_action_select == PIN_TOG |=> pin_ff != $past(pin_ff))
		else $error("pin did not toggle");
	a_pwm_force: assert property (@(posedge core_clk_i) disable iff (reset_i)
		is_pwm && ctrl1_ff.pin_action_select == PIN_LOW |=> pin_ff == $past(act_lvl))
		else $error("forced active level wrong");
	a_p_flag_set: assert property (@(posedge core_clk_i) disable iff (reset_i)
		!ctrl1_ff.counter_clear_select && cmp_like && match_p && !en_rise |=> fp_ff)
		else $error("match p flag missing");
	a_bus_ack: assert property (@(posedge core_clk_i) disable iff (reset_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");

	// properties below look one edge ahead of the registered state;
	// ten of them exclude an enable rise, which overrides every other counter update
	// and so would make the expected value ambiguous
	sequence s_bus_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ack_pulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence

	// a taken request is answered on the next edge, for exactly one cycle
	a_bus_answer: assert property (@(posedge core_clk_i) disable iff (reset_i)
		s_bus_take |=> s_ack_pulse)
		else $error("bus answer not one cycle after request");

	// write one clears a flag when no new match arrives
	a_status_clear: assert property (@(posedge core_clk_i) disable iff (reset_i)
		wr_strobe && req.adr == OFS_STATUS && req.dat[0] && !match_a |=> !fa_ff)
		else $error("match a flag not cleared");

	// a match in the clearing cycle must survive the clear
	a_flag_set_wins: assert property (@(posedge core_clk_i) disable iff (reset_i)
		match_a && (is_pwm || cmp_like) && !en_rise |=> fa_ff)
		else $error("match a flag lost");

	// flags are sticky until software writes the status word
	a_flag_hold: assert property (@(posedge core_clk_i) disable iff (reset_i)
		fa_ff && !wr_strobe |=> fa_ff)
		else $error("match a flag dropped by itself");

	// a stopped counter keeps its residual value
	a_cnt_hold_off: assert property (@(posedge core_clk_i) disable iff (reset_i)
		!ctrl0_ff.timer_enable |=> $stable(cnt_ff))
		else $error("counter moved while off");

	// plain counting step in compare, timer and capture modes
	a_cnt_step: assert property (@(posedge core_clk_i) disable iff (reset_i)
		run && !en_rise && !is_pwm && !match_a && !match_p |=> cnt_ff == $past(cnt_ff) + 10'h001)
		else $error("counter did not step");

	// pause freezes the count
	a_pause_hold: assert property (@(posedge core_clk_i) disable iff (reset_i)
		ctrl0_ff.pause && !en_rise |=> $stable(cnt_ff))
		else $error("counter moved while paused");

	// the low count byte reads live
	a_cnt_read_lo: assert property (@(posedge core_clk_i) disable iff (reset_i)
		rd_strobe && !req.we && req.adr == OFS_CNT_LO |=> wb_dat_o == {24'h000000, $past(cnt_ff[7:0])})
		else $error("count low byte read wrong");

	// unused high count bits read as zero
	a_cnt_read_hi: assert property (@(posedge core_clk_i) disable iff (reset_i)
		rd_strobe && !req.we && req.adr == OFS_CNT_HI |=> wb_dat_o[31:2] == 30'h0)
		else $error("count high byte upper bits not zero");

	// compare a low byte lands as written
	a_cmpa_write_lo: assert property (@(posedge core_clk_i) disable iff (reset_i)
		wr_strobe && req.adr == OFS_CMPA_LO |=> cmpa_ff[7:0] == $past(req.dat[7:0]))
		else $error("compare a low byte not stored");

	// compare a high byte keeps only two bits
	a_cmpa_write_hi: assert property (@(posedge core_clk_i) disable iff (reset_i)
		wr_strobe && req.adr == OFS_CMPA_HI |=> cmpa_ff[9:8] == $past(req.dat[1:0]))
		else $error("compare a high byte not stored");

	// timer mode releases the pin
	a_tmr_pin_off: assert property (@(posedge core_clk_i) disable iff (reset_i)
		ctrl1_ff.operating_mode_select == MODE_TMR |=> timer_pin_oe_n_o)
		else $error("pin driven in timer mode");

	// clear select 0: comparator p clears
	a_clr_on_p: assert property (@(posedge core_clk_i) disable iff (reset_i)
		cmp_like && !ctrl1_ff.counter_clear_select && match_p && !en_rise |=> cnt_ff == 10'h000)
		else $error("match p did not clear counter");

	// the top count always wraps to zero
	a_ovf_wrap: assert property (@(posedge core_clk_i) disable iff (reset_i)
		cmp_like && run && !en_rise && cnt_ff == CNT_MAX |=> cnt_ff == 10'h000)
		else $error("counter did not wrap");

	// compare mode pin moves only on a match a
	a_pin_only_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		ctrl1_ff.operating_mode_select == MODE_CMP && !match_a && !en_rise |=> $stable(pin_ff))
		else $error("pin moved without match a");

	// swap 0: comparator p ends the period
	a_pwm_period_p: assert property (@(posedge core_clk_i) disable iff (reset_i)
		is_pwm && run && !en_rise && !ctrl1_ff.period_duty_swap && match_p |=> cnt_ff == 10'h000)
		else $error("pwm period not ended by p");

	// swap 1: compare a ends the period
	a_pwm_period_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		is_pwm && run && !en_rise && ctrl1_ff.period_duty_swap && cnt_ff == cmpa_ff |=> cnt_ff == 10'h000)
		else $error("pwm period not ended by a");

	// duty at or past the period never ends the active phase
	a_pwm_full_duty: assert property (@(posedge core_clk_i) disable iff (reset_i)
		is_pwm && duty_v >= per_v && pwm_ff |=> pwm_ff)
		else $error("full duty dropped");

	// clear select and forced pin leave pwm counting alone
	a_pwm_counting: assert property (@(posedge core_clk_i) disable iff (reset_i)
		is_pwm && run && !en_rise && !ctrl1_ff.period_duty_swap && !match_p && cnt_ff != CNT_MAX
		|=> cnt_ff == $past(cnt_ff) + 10'h001)
		else $error("pwm counter did not step");

	// pwm raises the p flag on its match
	a_pwm_p_flag: assert property (@(posedge core_clk_i) disable iff (reset_i)
		is_pwm && match_p && !en_rise |=> match_p_flag_o)
		else $error("pwm match p flag missing");

	// forced inactive level follows polarity and invert
	a_pwm_inactive: assert property (@(posedge core_clk_i) disable iff (reset_i)
		is_pwm && ctrl1_ff.pin_action_select == PIN_NONE |=> pin_ff == !$past(act_lvl))
		else $error("forced inactive level wrong");

	// enable rise opens a pwm period in its active phase
	a_pwm_start: assert property (@(posedge core_clk_i) disable iff (reset_i)
		en_rise && is_pwm |=> pwm_ff)
		else $error("pwm did not start active");
endmodule

/* File: rtl/std_timer_pkg.sv */
// Purpose: shared constants and types for the 10-bit compare/pwm timer
// Assumes: wishbone classic slave, 8-bit registers in the low lane of a 32-bit word
// Notes:   offsets are byte addresses of aligned words
package std_timer_pkg;
	localparam logic [7:0] OFS_CTRL0   = 8'h00; // pause, clock select, enable, compare p value
	localparam logic [7:0] OFS_CTRL1   = 8'h04; // mode, pin action, level, invert, swap, clear select
	localparam logic [7:0] OFS_CNT_LO  = 8'h08;
	localparam logic [7:0] OFS_CNT_HI  = 8'h0c;
	localparam logic [7:0] OFS_CMPA_LO = 8'h10;
	localparam logic [7:0] OFS_CMPA_HI = 8'h14;
	localparam logic [7:0] OFS_STATUS  = 8'h18; // bit0 match_a_flag, bit1 match_p_flag, write 1 clears
	localparam logic [7:0] RST_BYTE    = 8'h00;
	localparam logic [9:0] CNT_MAX     = 10'h3ff;
	localparam int         P_SHIFT     = 7;     // comparator p sees counter bits 9..7
	// ctrl0 field positions
	localparam int C0_PAUSE = 7;
	localparam int C0_CKSEL = 4;
	localparam int C0_EN    = 3;
	localparam int C0_COMPARE_P_VALUE  = 0;
	// ctrl1 field positions
	localparam int C1_MODE  = 6;
	localparam int C1_PIN   = 4;
	localparam int C1_LEVEL = 3;
	localparam int C1_INV   = 2;
	localparam int C1_SWAP  = 1;
	localparam int C1_CLR   = 0;
	localparam logic [1:0] MODE_CMP  = 2'h0;
	localparam logic [1:0] MODE_CAP  = 2'h1;
	localparam logic [1:0] MODE_PWM  = 2'h2;
	localparam logic [1:0] MODE_TMR  = 2'h3;
	localparam logic [1:0] PIN_NONE  = 2'h0; // pwm: force inactive
	localparam logic [1:0] PIN_LOW   = 2'h1; // pwm: force active
	localparam logic [1:0] PIN_HIGH  = 2'h2; // pwm: waveform
	localparam logic [1:0] PIN_TOG   = 2'h3;
	typedef struct packed {
		logic       pause;
		logic [2:0] clk_sel;
		logic       timer_enable;
		logic [2:0] compare_p_value;
	} ctrl0_t;
	typedef struct packed {
		logic [1:0] operating_mode_select;
		logic [1:0] pin_action_select;
		logic       output_initial_level;
		logic       output_invert;
		logic       period_duty_swap;
		logic       counter_clear_select;
	} ctrl1_t;
	typedef struct packed {
		logic       cyc;
		logic       stb;
		logic       we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} wb_req_t;
endpackage

/* File: dv/pin_load.sv */
// Purpose: load on the timer output pin, counts driven high cycles and rising edges
// Assumes: pin sampled on core_clk_i, only while the timer drives it (oe_n low)
// Notes:   counts restart when the window opens, so results stay valid after it closes
module pin_load (
	input  wire logic core_clk_i,
	input  wire logic timer_pin_o,
	input  wire logic timer_pin_oe_n_o,
	input  wire logic win_i,
	output int        highs_o,
	output int        rises_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic last_ff = 1'b0;
	logic win_ff  = 1'b0;
	// an undriven pin is not counted: the load cannot see a level there
	always @(posedge core_clk_i) begin
		if (win_i && !win_ff) begin
			highs_o <= 0;
			rises_o <= 0;
		end else if (win_i && !timer_pin_oe_n_o) begin
			highs_o <= highs_o + int'(timer_pin_o);
			rises_o <= rises_o + int'(timer_pin_o && !last_ff);
		end
		last_ff <= timer_pin_o;
		win_ff  <= win_i;
	end
endmodule

/* File: dv/tb.sv */
// Purpose: self-checking bench for the compare/pwm timer
// Assumes: clock select 1 with tick_i[1] high every cycle, other tick bits random
// Notes:   pwm duty is measured over 1024 cycles with a small edge tolerance
module tb;
	import std_timer_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [7:0] tick_i = 8'h00;
	wb_req_t req = '0;
	logic [31:0] wb_dat_o, rd, lo;
	logic wb_ack_o, timer_pin_o, timer_pin_oe_n_o, match_a_flag_o, match_p_flag_o;
	logic win = 1'b0;
	logic [9:0] v;
	int highs, rises, e;
	int mismatches = 0;
	int n_compared = 0;
	int cycles = 0;
	std_timer i_dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .tick_i(tick_i), .wb_cyc_i(req.cyc),
		.wb_stb_i(req.stb), .wb_we_i(req.we), .wb_adr_i(req.adr), .wb_sel_i(req.sel), .wb_dat_i(req.dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer_pin_o(timer_pin_o),
		.timer_pin_oe_n_o(timer_pin_oe_n_o), .match_a_flag_o(match_a_flag_o), .match_p_flag_o(match_p_flag_o));
	pin_load i_load (.core_clk_i(core_clk_i), .timer_pin_o(timer_pin_o), .timer_pin_oe_n_o(timer_pin_oe_n_o),
		.win_i(win), .highs_o(highs), .rises_o(rises));
	always #20 core_clk_i = ~core_clk_i;
	// random tick enables; select 1 stays high so counting rate is known
	always @(posedge core_clk_i) begin
		tick_i <= 8'($urandom) | 8'h02;
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			mismatches++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_compared++;
		if (got !== ex) begin
			mismatches++;
			$display("mismatch %s expected %0h seen %0h", nm, ex, got);
		end
	endtask
	// one classic cycle; held until ack is sampled high, then released
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge core_clk_i);
		req <= '{1'b1, 1'b1, w, a, 4'h1, {24'h0, d}};
		do begin
			@(posedge core_clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n == 20)
			mismatches++;
		rd = wb_dat_o;
		req <= '0;
		@(posedge core_clk_i);
	endtask
	// stop, program, clear flags, then raise the enable so the counter restarts
	task automatic cfg(input logic [7:0] c1, input logic [2:0] p, input logic [9:0] a);
		wb(1'b1, OFS_CTRL0, {5'h02, p});
		wb(1'b1, OFS_CTRL1, c1);
		wb(1'b1, OFS_CMPA_LO, a[7:0]);
		wb(1'b1, OFS_CMPA_HI, {6'h00, a[9:8]});
		wb(1'b1, OFS_STATUS, 8'h03);
		wb(1'b1, OFS_CTRL0, {5'h03, p});
	endtask
	task automatic rdcnt();
		wb(1'b0, OFS_CNT_LO, 8'h00);
		lo = rd;
		wb(1'b0, OFS_CNT_HI, 8'h00);
		chk("count high unused bits", 32'h0, {rd[31:2], 2'b00});
		rd = {rd[1:0], lo[7:0]};
	endtask
	function automatic int pwm_high(input logic [1:0] pin, input logic sw, input int p, input int a);
		int per, dut;
		per = sw ? a : (p == 0 ? 1024 : p * 128);
		dut = sw ? (p == 0 ? 1024 : p * 128) : a;
		if (pin != PIN_HIGH)
			return pin == PIN_LOW ? 1024 : 0;
		return dut >= per ? 1024 : 1024 / per * dut;
	endfunction
	initial begin
		void'($urandom(32'he6ea));
		repeat (2) @(posedge core_clk_i);
		reset_i <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			wb(1'b0, 8'(8'h08 + 4 * i), 8'h00);
			chk("reset read", 32'h0, rd);
		end
		repeat (4) begin
			v = 10'($urandom);
			wb(1'b1, OFS_CMPA_LO, v[7:0]);
			wb(1'b1, OFS_CMPA_HI, {6'h3f, v[9:8]});
			wb(1'b0, OFS_CMPA_LO, 8'h00);
			chk("compare a low", {24'h0, v[7:0]}, rd);
			wb(1'b0, OFS_CMPA_HI, 8'h00);
			chk("compare a high", {30'h0, v[9:8]}, rd);
		end
		$display("test registers done");
		cfg({MODE_CMP, PIN_HIGH, 4'h1}, 3'h1, 10'd300);
		chk("pin initial", 32'h0, {31'h0, timer_pin_o});
		repeat (700) @(posedge core_clk_i);
		rdcnt();
		chk("clear on a", 32'h1, 32'(rd <= 300));
		chk("pin after match", 32'h1, {31'h0, timer_pin_o});
		chk("flags clear on a", 32'h1, {30'h0, match_p_flag_o, match_a_flag_o});
		for (int k = 0; k < 4; k++) begin
			cfg({MODE_CMP, 2'(k), 4'h9}, 3'h1, 10'd20);
			win <= 1'b1;
			repeat (500) @(posedge core_clk_i);
			win <= 1'b0;
			@(posedge core_clk_i);
			chk("toggle edges", 32'(k == 3), 32'(rises > 5));
			if (k != 3)
				chk("pin action level", 32'(k != 1), {31'h0, timer_pin_o});
		end
		cfg({MODE_CMP, PIN_NONE, 4'h0}, 3'h1, 10'd50);
		repeat (600) @(posedge core_clk_i);
		rdcnt();
		chk("clear on p", 32'h1, 32'(rd <= 128));
		chk("flags clear on p", 32'h3, {30'h0, match_p_flag_o, match_a_flag_o});
		cfg({MODE_TMR, PIN_HIGH, 4'h1}, 3'h1, 10'd60);
		repeat (100) @(posedge core_clk_i);
		chk("timer flag", 32'h1, {31'h0, match_a_flag_o});
		chk("timer pin unused", 32'h1, {31'h0, timer_pin_oe_n_o});
		cfg({MODE_CMP, PIN_TOG, 4'h0}, 3'h0, 10'd0);
		repeat (1100) @(posedge core_clk_i);
		chk("no a flag at zero", 32'h0, {31'h0, match_a_flag_o});
		wb(1'b1, OFS_CTRL0, 8'h10);
		rdcnt();
		e = int'(rd);
		repeat (50) @(posedge core_clk_i);
		rdcnt();
		chk("count held when off", 32'(e), rd);
		$display("test compare modes done");
		for (int k = 0; k < 5; k++) begin
			logic [1:0] pn;
			logic sw;
			pn = k == 2 ? PIN_NONE : (k == 3 ? PIN_LOW : PIN_HIGH);
			sw = k == 1;
			cfg({MODE_PWM, pn, 4'h8 | {1'b0, k == 4, sw, 1'b0}}, 3'h1, sw ? 10'd100 : 10'd32);
			repeat (256) @(posedge core_clk_i);
			win <= 1'b1;
			repeat (1024) @(posedge core_clk_i);
			win <= 1'b0;
			@(posedge core_clk_i);
			e = pwm_high(pn, sw, 1, sw ? 100 : 32);
			if (k == 4)
				e = 1024 - e; // inverted pin shows the complement
			chk("pwm high cycles", 32'h1, 32'(highs >= e - 4 && highs <= e + 4));
			chk("pwm a flag", 32'h1, {31'h0, match_a_flag_o});
		end
		$display("test pwm done");
		finish_test();
	end
endmodule
